// File: rtl/twmsf_consts.svh
// twmsf_consts: offsets, bit positions, status codes and timing of the two-wire unit
// assumes: included by bare name from rtl files, no code of its own
`ifndef TWMSF_CONSTS_SVH
`define TWMSF_CONSTS_SVH
// register offsets
`define TW_A_CTRL   3'h0
`define TW_A_DATA   3'h1
`define TW_A_STAT   3'h2
`define TW_A_OWN    3'h3
`define TW_A_IRQS   3'h4
`define TW_A_IRQM   3'h5
// control_reg bit positions
`define TW_CB_FLAG  7
`define TW_CB_ACK   6
`define TW_CB_STA   5
`define TW_CB_STO   4
`define TW_CB_WCOL  3
`define TW_CB_EN    2
// interrupt status bit positions
`define TW_IB_FLAG  0
`define TW_IB_WCOL  1
`define TW_IB_ARB   2
// state codes, low three bits always zero
`define TW_C_START     8'h08
`define TW_C_RSTART    8'h10
`define TW_C_WA_ACK    8'h18
`define TW_C_WA_NACK   8'h20
`define TW_C_WD_ACK    8'h28
`define TW_C_WD_NACK   8'h30
`define TW_C_ARB       8'h38
`define TW_C_RA_ACK    8'h40
`define TW_C_RA_NACK   8'h48
`define TW_C_RD_ACK    8'h50
`define TW_C_RD_NACK   8'h58
`define TW_C_SLV_WADDR 8'h60
`define TW_C_SLV_RXACK 8'h80
`define TW_C_SLV_RXNAK 8'h88
`define TW_C_SLV_END   8'hA0
`define TW_C_SLV_RADDR 8'hA8
`define TW_C_SLV_TXACK 8'hB8
`define TW_C_SLV_TXNAK 8'hC0
`define TW_C_NONE      8'hF8
// bit slots: 0..7 data, 8 acknowledge
`define TW_LAST_DATA 4'h7
`define TW_ACK_SLOT  4'h8
// half period of the generated clock
`define TW_CLK_NS    10
`define TW_HALF_NS   5000
`define TW_HALF_CYC  (`TW_HALF_NS / `TW_CLK_NS)
`endif

// File: rtl/twmsf_pkg.sv
// twmsf_pkg: state and role types of the two-wire unit
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package twmsf_pkg;
	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_START_A = 3'b001,
		S_START_B = 3'b010,
		S_HOLD    = 3'b011,
		S_BITS    = 3'b100,
		S_STOP_A  = 3'b101,
		S_STOP_B  = 3'b110
	} twmsf_state_t;
	typedef enum logic [1:0] {
		master_send_role    = 2'b00,
		master_receive_role = 2'b01,
		slave_send_role     = 2'b10,
		slave_receive_role  = 2'b11
	} twmsf_role_t;
endpackage
`default_nettype wire

// File: rtl/twmsf_line_sync.sv
// twmsf_line_sync: two-flop synchronisers and edge pulses for the bus lines
// assumes: lines idle high, core clock much faster than the bus clock
`timescale 1ns/1ns
`default_nettype none
module twmsf_line_sync (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	// raw pad levels
	input  wire logic scl_i,
	input  wire logic sda_i,
	// synchronised levels and one-cycle edges
	output logic      scl_s_o,
	output logic      sda_s_o,
	output logic      scl_rise_o,
	output logic      scl_fall_o,
	output logic      sda_rise_o,
	output logic      sda_fall_o
);
	logic [1:0] meta_ff;
	logic [1:0] sync_ff;
	logic [1:0] last_ff;

	// meta_ff is read by sync_ff only
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			meta_ff <= 2'h3;
			sync_ff <= 2'h3;
			last_ff <= 2'h3;
		end else begin
			meta_ff <= {scl_i, sda_i};
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign scl_s_o    = sync_ff[1];
	assign sda_s_o    = sync_ff[0];
	assign scl_rise_o = sync_ff[1] && !last_ff[1];
	assign scl_fall_o = !sync_ff[1] && last_ff[1];
	assign sda_rise_o = sync_ff[0] && !last_ff[0];
	assign sda_fall_o = !sync_ff[0] && last_ff[0];
endmodule // twmsf_line_sync
`default_nettype wire

// File: rtl/twmsf_core.sv
// twmsf_core: byte-oriented two-wire serial unit with flag-driven handshake
// assumes: one 100 MHz clock, synchronous reset, open-drain pads resolved outside
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "twmsf_consts.svh"

module twmsf_core (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	// register port
	input  wire logic [2:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	output logic            irq_o,
	// bus pads, enable low while driving low
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oen_o,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oen_o
);
	import twmsf_pkg::*;

	twmsf_state_t st_ff;
	twmsf_role_t  role_ff;
	logic         flag_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff, en_ff;
	logic [7:0]   byte_buf_ff, code_ff, rdata_ff;
	logic [1:0]   presc_ff;
	logic [6:0]   own_addr_ff;
	logic [2:0]   irq_st_ff, irq_mask_ff;
	logic         irq_ff, low_ff, set_req_ff, busy_ff;
	logic [3:0]   bit_cnt_ff;
	logic         addr_ph_ff, master_ff, rep_ff, done_ff, ack_seen_ff;
	logic         scl_oen_ff, sda_oen_ff;
	logic [8:0]   div_ff;
	logic         scl_s, sda_s, scl_rise, scl_fall, sda_rise, sda_fall;
	logic         wr_ctrl, wr_data, sw_clr, go, tick, start_det, stop_det, rw_bit;
	logic         sending, lost, stop_fin, sto_done, byte_end, slv_gone;

	function automatic logic reg_hit(input logic [2:0] a, input logic [2:0] r);
		reg_hit = (a == r);
	endfunction

	// code reported when an acknowledge slot closes
	function automatic logic [7:0] done_code(input logic addr, input logic mst,
			input twmsf_role_t r, input logic rw, input logic nak, input logic ack_en);
		if (addr && mst)
			done_code = rw ? (nak ? `TW_C_RA_NACK : `TW_C_RA_ACK)
				: (nak ? `TW_C_WA_NACK : `TW_C_WA_ACK);
		else if (addr)
			done_code = rw ? `TW_C_SLV_RADDR : `TW_C_SLV_WADDR;
		else if (r == master_send_role)
			done_code = nak ? `TW_C_WD_NACK : `TW_C_WD_ACK;
		else if (r == master_receive_role)
			done_code = ack_en ? `TW_C_RD_ACK : `TW_C_RD_NACK;
		else if (r == slave_send_role)
			done_code = nak ? `TW_C_SLV_TXNAK : `TW_C_SLV_TXACK;
		else
			done_code = ack_en ? `TW_C_SLV_RXACK : `TW_C_SLV_RXNAK;
	endfunction

	twmsf_line_sync u_sync (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.scl_s_o    (scl_s),
		.sda_s_o    (sda_s),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.sda_rise_o (sda_rise),
		.sda_fall_o (sda_fall)
	);

	assign wr_ctrl   = reg_wr_i && reg_hit(reg_addr_i, `TW_A_CTRL);
	assign wr_data   = reg_wr_i && reg_hit(reg_addr_i, `TW_A_DATA);
	assign sw_clr    = wr_ctrl && reg_wdata_i[`TW_CB_FLAG];
	assign go        = flag_ff && sw_clr && reg_wdata_i[`TW_CB_EN];
	assign tick      = (div_ff == 9'h000);
	assign start_det = sda_fall && scl_s;
	assign stop_det  = sda_rise && scl_s;
	assign rw_bit    = byte_buf_ff[0];
	assign sending   = addr_ph_ff ? master_ff
		: (role_ff == master_send_role || role_ff == slave_send_role);
	// a released data line read back low means another master won
	assign lost      = st_ff == S_BITS && master_ff && sending && scl_rise && sda_oen_ff
		&& !sda_s && bit_cnt_ff != `TW_ACK_SLOT;
	assign stop_fin  = st_ff == S_STOP_B && tick && scl_s;
	assign sto_done  = stop_fin || (st_ff == S_IDLE && sto_ff);
	assign byte_end  = st_ff == S_BITS && scl_fall && bit_cnt_ff == `TW_ACK_SLOT;
	assign slv_gone  = !master_ff && !addr_ph_ff && !done_ff && (stop_det || start_det)
		&& (st_ff == S_BITS || st_ff == S_HOLD);

	// bus engine
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_ff       <= S_IDLE;
			role_ff     <= master_send_role;
			byte_buf_ff <= 8'h00;
			code_ff     <= `TW_C_NONE;
			bit_cnt_ff  <= 4'h0;
			addr_ph_ff  <= 1'b0;
			master_ff   <= 1'b0;
			rep_ff      <= 1'b0;
			done_ff     <= 1'b0;
			ack_seen_ff <= 1'b1;
			set_req_ff  <= 1'b0;
			scl_oen_ff  <= 1'b1;
			sda_oen_ff  <= 1'b1;
		end else begin
			set_req_ff <= 1'b0;
			if (wr_data && flag_ff) begin
				byte_buf_ff <= reg_wdata_i;
			end
			if (!en_ff) begin
				st_ff      <= S_IDLE;
				master_ff  <= 1'b0;
				scl_oen_ff <= 1'b1;
				sda_oen_ff <= 1'b1;
			end else if (slv_gone) begin
				code_ff    <= `TW_C_SLV_END;
				set_req_ff <= 1'b1;
				done_ff    <= 1'b1;
				scl_oen_ff <= 1'b1;
				sda_oen_ff <= 1'b1;
				st_ff      <= S_HOLD;
			end else begin
				case (st_ff)
				S_IDLE: begin
					scl_oen_ff <= 1'b1;
					sda_oen_ff <= 1'b1;
					master_ff  <= 1'b0;
					// roles are whatever software asks for; a master start also waits for !busy_ff
					if (sta_ff && !busy_ff) begin
						st_ff  <= S_START_A;
						rep_ff <= 1'b0;
					end else if (ack_en_ff && start_det) begin
						st_ff      <= S_BITS;
						bit_cnt_ff <= 4'h0;
						addr_ph_ff <= 1'b1;
						done_ff    <= 1'b0;
					end
				end
				S_START_A: begin
					sda_oen_ff <= 1'b1;
					if (tick) begin
						scl_oen_ff <= 1'b1;
						if (scl_oen_ff && scl_s && sda_s && (rep_ff || !busy_ff)) begin
							sda_oen_ff <= 1'b0;
							st_ff      <= S_START_B;
						end
					end
				end
				S_START_B: begin
					if (tick) begin
						scl_oen_ff <= 1'b0;
						master_ff  <= 1'b1;
						addr_ph_ff <= 1'b1;
						done_ff    <= 1'b0;
						code_ff    <= rep_ff ? `TW_C_RSTART : `TW_C_START;
						set_req_ff <= 1'b1;
						st_ff      <= S_HOLD;
					end
				end
				S_HOLD: begin
					// clock stays stretched low until software clears the flag, unless done_ff is set
					if (!done_ff) begin
						scl_oen_ff <= 1'b0;
					end
					if (go) begin
						code_ff <= `TW_C_NONE;
						if (done_ff) begin
							st_ff      <= S_IDLE;
							scl_oen_ff <= 1'b1;
							sda_oen_ff <= 1'b1;
						end else if (master_ff && reg_wdata_i[`TW_CB_STO]) begin
							st_ff      <= S_STOP_A;
							sda_oen_ff <= 1'b0;
						end else if (master_ff && reg_wdata_i[`TW_CB_STA]) begin
							st_ff      <= S_START_A;
							rep_ff     <= 1'b1;
							sda_oen_ff <= 1'b1;
						end else begin
							st_ff      <= S_BITS;
							bit_cnt_ff <= 4'h0;
							sda_oen_ff <= sending ? byte_buf_ff[7] : 1'b1;
							if (!master_ff) begin
								scl_oen_ff <= 1'b1;
							end
						end
					end
				end
				S_BITS: begin
					if (master_ff && tick) begin
						if (!scl_oen_ff) begin
							scl_oen_ff <= 1'b1;
						end else if (scl_s) begin
							scl_oen_ff <= 1'b0;
						end
					end
					if (lost) begin
						code_ff    <= `TW_C_ARB;
						set_req_ff <= 1'b1;
						master_ff  <= 1'b0;
						done_ff    <= 1'b1;
						scl_oen_ff <= 1'b1;
						sda_oen_ff <= 1'b1;
						st_ff      <= S_HOLD;
					end else if (scl_rise) begin
						if (bit_cnt_ff == `TW_ACK_SLOT) begin
							ack_seen_ff <= sda_s;
						end else begin
							byte_buf_ff <= {byte_buf_ff[6:0], sda_s};
						end
					end else if (byte_end) begin
						bit_cnt_ff <= 4'h0;
						st_ff      <= S_HOLD;
						scl_oen_ff <= 1'b0;
						sda_oen_ff <= 1'b1;
						set_req_ff <= 1'b1;
						addr_ph_ff <= 1'b0;
						code_ff    <= done_code(addr_ph_ff, master_ff, role_ff, rw_bit,
							ack_seen_ff, ack_en_ff);
						if (addr_ph_ff && master_ff) begin
							role_ff <= rw_bit ? master_receive_role : master_send_role;
						end else if (addr_ph_ff) begin
							role_ff <= rw_bit ? slave_send_role : slave_receive_role;
						end
						done_ff <= !master_ff && !addr_ph_ff
							&& (role_ff == slave_send_role ? ack_seen_ff : !ack_en_ff);
					end else if (scl_fall) begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == `TW_LAST_DATA) begin
							if (sending) begin
								sda_oen_ff <= 1'b1;
							end else if (addr_ph_ff && !master_ff
								&& (byte_buf_ff[7:1] != own_addr_ff || !ack_en_ff)) begin
								st_ff      <= S_IDLE;
								sda_oen_ff <= 1'b1;
							end else begin
								sda_oen_ff <= !ack_en_ff;
							end
						end else begin
							sda_oen_ff <= sending ? byte_buf_ff[7] : 1'b1;
						end
					end
				end
				S_STOP_A: begin
					if (tick) begin
						scl_oen_ff <= 1'b1;
						st_ff      <= S_STOP_B;
					end
				end
				S_STOP_B: begin
					if (stop_fin) begin
						sda_oen_ff <= 1'b1;
						master_ff  <= 1'b0;
						st_ff      <= S_IDLE;
					end
				end
				default: st_ff <= S_IDLE;
				endcase
			end
		end
	end

	// control_reg: flag set by hardware wins over a software clear
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			flag_ff   <= 1'b0;
			ack_en_ff <= 1'b0;
			sta_ff    <= 1'b0;
			sto_ff    <= 1'b0;
			wcol_ff   <= 1'b0;
			en_ff     <= 1'b0;
		end else begin
			if (set_req_ff) begin
				flag_ff <= 1'b1;
			end else if (sw_clr) begin
				flag_ff <= 1'b0;
			end
			if (wr_ctrl) begin
				ack_en_ff <= reg_wdata_i[`TW_CB_ACK];
				sta_ff    <= reg_wdata_i[`TW_CB_STA];
				en_ff     <= reg_wdata_i[`TW_CB_EN];
				sto_ff    <= reg_wdata_i[`TW_CB_STO];
			end else if (sto_done) begin
				sto_ff <= 1'b0;
			end
			if (wr_data) begin
				wcol_ff <= !flag_ff;
			end
		end
	end

	// plain software registers
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			presc_ff    <= 2'h0;
			own_addr_ff <= 7'h00;
			irq_mask_ff <= 3'h0;
		end else if (reg_wr_i) begin
			if (reg_hit(reg_addr_i, `TW_A_STAT)) begin
				presc_ff <= reg_wdata_i[1:0];
			end else if (reg_hit(reg_addr_i, `TW_A_OWN)) begin
				own_addr_ff <= reg_wdata_i[7:1];
			end else if (reg_hit(reg_addr_i, `TW_A_IRQM)) begin
				irq_mask_ff <= reg_wdata_i[2:0];
			end
		end
	end

	// sticky events, a read clears them but an event in that cycle survives
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			irq_st_ff <= 3'h0;
			irq_ff    <= 1'b0;
		end else begin
			irq_st_ff <= ((reg_rd_i && reg_hit(reg_addr_i, `TW_A_IRQS)) ? 3'h0 : irq_st_ff)
				| {set_req_ff && code_ff == `TW_C_ARB, wr_data && !flag_ff, set_req_ff};
			irq_ff    <= |(irq_st_ff & irq_mask_ff);
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !reg_rd_i) begin
			rdata_ff <= 8'h00;
		end else if (reg_hit(reg_addr_i, `TW_A_CTRL)) begin
			rdata_ff <= {flag_ff, ack_en_ff, sta_ff, sto_ff, wcol_ff, en_ff, 2'h0};
		end else if (reg_hit(reg_addr_i, `TW_A_DATA)) begin
			rdata_ff <= byte_buf_ff;
		end else if (reg_hit(reg_addr_i, `TW_A_STAT)) begin
			rdata_ff <= {code_ff[7:3], 1'b0, presc_ff};
		end else if (reg_hit(reg_addr_i, `TW_A_OWN)) begin
			rdata_ff <= {own_addr_ff, 1'b0};
		end else if (reg_hit(reg_addr_i, `TW_A_IRQS)) begin
			rdata_ff <= {5'h00, irq_st_ff};
		end else if (reg_hit(reg_addr_i, `TW_A_IRQM)) begin
			rdata_ff <= {5'h00, irq_mask_ff};
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// bus busy tracking and bit-rate divider, restarted on every resume
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || stop_det) begin
			busy_ff <= 1'b0;
		end else if (start_det) begin
			busy_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || st_ff == S_IDLE || go || tick) begin
			div_ff <= 9'(`TW_HALF_CYC - 1);
		end else begin
			div_ff <= div_ff - 9'h001;
		end
	end

	always_ff @(posedge core_clk_i) begin
		low_ff <= 1'b0;
	end

	assign reg_rdata_o = rdata_ff;
	assign irq_o       = irq_ff;
	assign scl_o       = low_ff;
	assign sda_o       = low_ff;
	assign scl_oen_o   = scl_oen_ff;
	assign sda_oen_o   = sda_oen_ff;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_flag_up;
		set_req_ff ##1 flag_ff;
	endsequence

	property p_byte_flag;
		byte_end && !slv_gone && en_ff |=> s_flag_up;
	endproperty
	a_byte_flag: assert property (p_byte_flag) else $error("flag not raised after byte");

	property p_hold;
		st_ff == S_HOLD && flag_ff && !sw_clr && !done_ff && en_ff && !slv_gone
			|=> st_ff == S_HOLD && !scl_oen_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("transfer moved while flag set");

	// a bit sampled in the same cycle still shifts the buffer, so that cycle is left out
	property p_wcol;
		wr_data && !flag_ff && !set_req_ff && !(st_ff == S_BITS && scl_rise)
			|=> wcol_ff && byte_buf_ff == $past(byte_buf_ff);
	endproperty
	a_wcol: assert property (p_wcol) else $error("write collision not handled");

	property p_code_valid;
		$rose(flag_ff) |-> code_ff != `TW_C_NONE;
	endproperty
	a_code_valid: assert property (p_code_valid) else $error("flag set without code");

	property p_addr_wack;
		byte_end && !slv_gone && en_ff && addr_ph_ff && master_ff && !ack_seen_ff && !rw_bit
			|=> code_ff == `TW_C_WA_ACK && role_ff == master_send_role ##1 flag_ff;
	endproperty
	a_addr_wack: assert property (p_addr_wack) else $error("address write ack code wrong");

	property p_data_code;
		byte_end && !slv_gone && en_ff && !addr_ph_ff && role_ff == master_send_role
			|=> code_ff == ($past(ack_seen_ff) ? `TW_C_WD_NACK : `TW_C_WD_ACK);
	endproperty
	a_data_code: assert property (p_data_code) else $error("data byte code wrong");

	property p_role;
		byte_end && !slv_gone && en_ff && addr_ph_ff && master_ff
			|=> role_ff == ($past(rw_bit) ? master_receive_role : master_send_role);
	endproperty
	a_role: assert property (p_role) else $error("role after address wrong");

	property p_stop_clear;
		stop_fin && en_ff && !wr_ctrl |=> !sto_ff && st_ff == S_IDLE && sda_oen_ff;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop request not cleared");

	property p_slots;
		st_ff == S_BITS |-> bit_cnt_ff <= `TW_ACK_SLOT;
	endproperty
	a_slots: assert property (p_slots) else $error("more than nine bit slots");

	property p_resume;
		st_ff == S_HOLD && go && en_ff && !done_ff && !slv_gone && !reg_wdata_i[`TW_CB_STO]
			&& !reg_wdata_i[`TW_CB_STA] |=> st_ff == S_BITS && bit_cnt_ff == 4'h0;
	endproperty
	a_resume: assert property (p_resume) else $error("flag clear did not resume");
endmodule // twmsf_core
`default_nettype wire

// File: test/twmsf_slave_model.sv
// twmsf_slave_model: behavioural bus slave that accepts every byte unless told to refuse
// assumes: resolved open-drain levels at its inputs, pull-ups, no clock stretching
`timescale 1ns/1ns
`default_nettype none
module twmsf_slave_model (
	// resolved bus levels
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// refuse the coming acknowledge slots
	input  wire logic       nack_i,
	// data pull, low while driving; last byte and slot count seen
	output logic            sda_oen_o,
	output logic      [7:0] byte_o,
	output logic      [3:0] cnt_o
);
	logic [7:0] shift;
	initial begin
		sda_oen_o = 1'b1;
		byte_o = 8'h00;
		cnt_o = 4'h0;
		shift = 8'h00;
	end
	// a start (data falls, clock high) restarts the slot count
	always @(negedge sda_i) begin
		if (scl_i) begin
			cnt_o = 4'h0;
		end
	end
	always @(posedge scl_i) begin
		if (cnt_o < 4'h8) begin
			shift = {shift[6:0], sda_i};
		end
		cnt_o = cnt_o + 4'h1;
		if (cnt_o == 4'h8) begin
			byte_o = shift;
		end
	end
	// change the pull only when the clock falls, so no false start or stop appears
	always @(negedge scl_i) begin
		sda_oen_o = !(cnt_o == 4'h8 && !nack_i);
		if (cnt_o == 4'h9) begin
			cnt_o = 4'h0;
		end
	end
endmodule // twmsf_slave_model
`default_nettype wire

// File: test/two_wire_master_send_flow_tb.sv
// two_wire_master_send_flow_tb: register-driven master transfers against a slave model
// assumes: twmsf_core and twmsf_line_sync compiled before, constants header on the path
`timescale 1ns/1ns
`default_nettype none
`include "twmsf_consts.svh"
module two_wire_master_send_flow_tb;
	logic        core_clk_i;
	logic        sys_rst_i;
	logic [2:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic        nack;
	logic [7:0]  reg_rdata_o;
	logic        irq_o;
	logic        scl_o;
	logic        scl_oen_o;
	logic        sda_o;
	logic        sda_oen_o;
	logic        slv_oen;
	logic [7:0]  slv_byte;
	logic [3:0]  slv_cnt;
	logic [7:0]  d;
	int          num_errors;
	int          total_checks;
	int          cycles = 0;
	wire         scl_w = scl_oen_o;
	wire         sda_w = sda_oen_o & slv_oen;
	// reset rows: register index beside its reset value, the last one unmapped
	localparam logic [10:0] ROWS [7] = '{11'h000, 11'h100, 11'h2F8, 11'h300, 11'h400,
		11'h500, 11'h600};

	twmsf_core i_twmsf_core (
		.core_clk_i (core_clk_i), .sys_rst_i (sys_rst_i), .reg_addr_i (reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i (reg_wr_i), .reg_rd_i (reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .irq_o (irq_o), .scl_i (scl_w), .scl_o (scl_o),
		.scl_oen_o (scl_oen_o), .sda_i (sda_w), .sda_o (sda_o), .sda_oen_o (sda_oen_o));
	twmsf_slave_model i_twmsf_slave_model (
		.scl_i (scl_w), .sda_i (sda_w), .nack_i (nack), .sda_oen_o(slv_oen),
		.byte_o(slv_byte), .cnt_o (slv_cnt));

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic results();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard: the whole sequence needs about 55000 cycles
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			num_errors++;
			results();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe is taken
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask

	task automatic wait_flag_code(input logic [7:0] code);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 20000 && c[`TW_CB_FLAG] !== 1'b1; i++) rd(`TW_A_CTRL, c);
		rd(`TW_A_STAT, c);
		chk("state code", c & 8'hF8, code);
	endtask

	task automatic send(input logic [7:0] b, input logic [7:0] code);
		wr(`TW_A_DATA, b);
		wr(`TW_A_CTRL, 8'h84);
		wait_flag_code(code);
	endtask

	task automatic stop_bus();
		logic [7:0] c;
		wr(`TW_A_CTRL, 8'h94);
		c = 8'h10;
		for (int i = 0; i < 5000 && c[`TW_CB_STO] !== 1'b0; i++) rd(`TW_A_CTRL, c);
		chk("stop bit", c & 8'h10, 8'h00);
		repeat (4) @(posedge core_clk_i);
		chk("released lines", {6'h00, scl_oen_o, sda_oen_o}, 8'h03);
	endtask

	initial begin
		sys_rst_i = 1'b1;
		reg_addr_i = 3'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		nack = 1'b0;
		num_errors = 0;
		total_checks = 0;
		repeat (12) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge core_clk_i);
		chk("reset pins", {3'h0, scl_o, sda_o, irq_o, scl_oen_o, sda_oen_o}, 8'h03);
		foreach (ROWS[i]) begin
			rd(ROWS[i][10:8], d);
			chk("reset read", d, ROWS[i][7:0]);
		end
		// byte buffer write with the flag low is dropped
		wr(`TW_A_IRQM, 8'h03);
		wr(`TW_A_DATA, 8'h5A);
		rd(`TW_A_CTRL, d);
		chk("collision bit", d & 8'h08, 8'h08);
		rd(`TW_A_DATA, d);
		chk("dropped byte", d, 8'h00);
		chk("irq raised", {7'h00, irq_o}, 8'h01);
		rd(`TW_A_IRQS, d);
		chk("irq status", d, 8'h02);
		repeat (3) @(posedge core_clk_i);
		chk("irq cleared", {7'h00, irq_o}, 8'h00);
		// master write: start, address with write, two bytes, stop
		wr(`TW_A_CTRL, 8'hA4);
		wait_flag_code(`TW_C_START);
		chk("flag irq", {7'h00, irq_o}, 8'h01);
		send(8'hA4, `TW_C_WA_ACK);
		chk("address byte", slv_byte, 8'hA4);
		// transfer must stay frozen while the flag is set
		repeat (1500) @(posedge core_clk_i);
		chk("held clock", {3'h0, scl_oen_o, slv_cnt}, 8'h00);
		send(8'h3C, `TW_C_WD_ACK);
		chk("data byte", slv_byte, 8'h3C);
		nack <= 1'b1;
		send(8'hC3, `TW_C_WD_NACK);
		chk("refused byte", slv_byte, 8'hC3);
		nack <= 1'b0;
		stop_bus();
		// read direction enters the receive role
		wr(`TW_A_CTRL, 8'hA4);
		wait_flag_code(`TW_C_START);
		send(8'hA5, `TW_C_RA_ACK);
		chk("read address", slv_byte, 8'hA5);
		// repeated start from the receive role, then back to sending
		wr(`TW_A_CTRL, 8'hA4);
		wait_flag_code(`TW_C_RSTART);
		send(8'hA4, `TW_C_WA_ACK);
		chk("new address", slv_byte, 8'hA4);
		stop_bus();
		// reset in mid-transfer with the clock held low: all back to idle
		wr(`TW_A_CTRL, 8'hA4);
		wait_flag_code(`TW_C_START);
		@(posedge core_clk_i);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rd(`TW_A_CTRL, d);
		chk("ctrl after reset", d, 8'h00);
		rd(`TW_A_STAT, d);
		chk("code after reset", d, `TW_C_NONE);
		chk("pins after reset", {3'h0, scl_o, sda_o, irq_o, scl_oen_o, sda_oen_o}, 8'h03);
		results();
	end
endmodule // two_wire_master_send_flow_tb
`default_nettype wire
